// ==== hdl/gpc_map.svh ====
// Purpose: offsets, codes, reset values and timing for the pin controller
// Assumes: 25 MHz system clock
// Notes: included by every design file except gpc_pkg
`ifndef GPC_MAP_SVH
`define GPC_MAP_SVH

// ******************************************************************
// Command and response codes
// ******************************************************************
`define GPC_CMD_SET 8'h22
`define GPC_CMD_QRY 8'h23
`define GPC_RSP_SET 8'h62
`define GPC_RSP_QRY 8'h63
`define GPC_RSP_ERR_BASE 8'hC0
`define GPC_RSP_QRY_LEN 3'h4

// ******************************************************************
// Pin map and field layout
// ******************************************************************
`define GPC_NUM_GPIO 5
`define GPC_NUM_PINS 13
`define GPC_IDX_LIMIT 8'h0D
`define GPC_VAL_HIGH 8'h64
`define GPC_CFG_FUNC_BIT 3
`define GPC_DRV_RESERVED 3'h6

// ******************************************************************
// Reset values (factory default)
// ******************************************************************
`define GPC_RST_GPIO_CFG 4'h2
`define GPC_RST_LED_CFG 4'h1
`define GPC_RST_VAL 8'h00

// ******************************************************************
// Timing
// ******************************************************************
`define GPC_CLK_HZ 25000000
`define GPC_PWM_HZ 100
`define GPC_DUTY_STEPS 100
`define GPC_SAMPLE_HZ 32
`define GPC_STEP_CYC (`GPC_CLK_HZ / (`GPC_PWM_HZ * `GPC_DUTY_STEPS))
`define GPC_SAMPLE_CYC (`GPC_CLK_HZ / `GPC_SAMPLE_HZ)

`endif

// ==== hdl/gpc_pkg.sv ====
// Purpose: shared types of the pin controller
// Assumes: nothing
// Notes: constants live in gpc_map.svh
package gpc_pkg;

   typedef logic [7:0] gpc_byte_t;

   // Drive field codes
   typedef enum logic [2:0] {
      GPC_DRV_UP_PD = 3'h0,
      GPC_DRV_FAST = 3'h1,
      GPC_DRV_HIZ = 3'h2,
      GPC_DRV_PU_DN = 3'h3,
      GPC_DRV_SLOW_UP = 3'h4,
      GPC_DRV_SLOW = 3'h5,
      GPC_DRV_RSVD = 3'h6,
      GPC_DRV_SLOW_DN = 3'h7
   } gpc_drive_e;

endpackage

// ==== hdl/gpc_pin_drive.sv ====
// Purpose: turns one pin's drive field and level into pad controls
// Assumes: level is synchronous to sys_clk
// Notes: all outputs registered
`timescale 1ns/10ps
`include "gpc_map.svh"
module gpc_pin_drive
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [2:0] drive_mode_field,
   input wire logic level,
   output logic pad_out,
   output logic pad_oe,
   output logic pad_pu,
   output logic pad_pd,
   output logic pad_slow
);
   import gpc_pkg::*;

   logic next_out;
   logic next_oe;
   logic next_pu;
   logic next_pd;
   logic next_slow;

   // ******************************************************************
   // Drive decode
   // ******************************************************************
   always_comb
   begin
      next_out = level;
      next_oe = 1'b0;
      next_pu = 1'b0;
      next_pd = 1'b0;
      next_slow = 1'b0;
      case (gpc_drive_e'(drive_mode_field))
         GPC_DRV_UP_PD:
         begin
            next_oe = level; // RQ11
            next_pd = !level; // RQ11
         end
         GPC_DRV_FAST:
         begin
            next_oe = 1'b1; // RQ11
         end
         GPC_DRV_PU_DN:
         begin
            next_oe = !level; // RQ11
            next_pu = level; // RQ11 RQ6
         end
         GPC_DRV_SLOW_UP:
         begin
            next_oe = level; // RQ12
            next_slow = 1'b1;
         end
         GPC_DRV_SLOW:
         begin
            next_oe = 1'b1; // RQ12
            next_slow = 1'b1;
         end
         GPC_DRV_SLOW_DN:
         begin
            next_oe = !level; // RQ12
            next_slow = 1'b1;
         end
         default:
         begin
            next_oe = 1'b0; // RQ12
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pad_out <= 1'b0;
         pad_oe <= 1'b0;
         pad_pu <= 1'b0;
         pad_pd <= 1'b0;
         pad_slow <= 1'b0;
      end
      else
      begin
         pad_out <= next_out;
         pad_oe <= next_oe;
         pad_pu <= next_pu;
         pad_pd <= next_pd;
         pad_slow <= next_slow;
      end
   end

   // ******************************************************************
   // Checks
   // ******************************************************************
   a_hiz_mode_idle: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ12
      drive_mode_field == 3'h2 |=> !pad_oe && !pad_pu && !pad_pd)
      else $error("hi-z mode drives the pad");
   a_fast_both_ways: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ11
      drive_mode_field == 3'h1 |=> pad_oe && !pad_slow && pad_out == $past(level))
      else $error("fast drive does not follow level");
   a_pullup_high: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ6
      drive_mode_field == 3'h3 && level |=> pad_pu && !pad_oe)
      else $error("pull-up mode not resistive high");

endmodule

// ==== hdl/gpc_pin_ctrl.sv ====
// Purpose: command-driven control of five general pins and eight LED lines
// Assumes: command fields are synchronous; gpio_in comes from pins
// Notes: responses come one cycle after the command
//
// Behaviour
// RQ1: five shared general pins, input or output
// RQ2: outputs drive high, low or 100 Hz PWM
// RQ3: sample every general pin at 32 Hz
// RQ4: latch rise and fall seen since last query
// RQ5: slow sampling debounces the inputs
// RQ6: pull-up mode reads open switch as one
// RQ7: set command 0x22, two or three bytes
// RQ8: index 0-4 general, 5-12 LED, rest invalid
// RQ9: value 0 low, 1-99 duty, 100 high
// RQ10: host config byte within 0-15
// RQ11: drive codes 000, 001, 011 as listed
// RQ12: drive codes 010, 100, 101, 111 as listed
// RQ13: drive code 110 answers an error
// RQ14: function bit zero gives default role
// RQ15: LED lines ignore the function bit
// RQ16: factory roles sense, power, reset, one-wire
// RQ17: pin configuration saved as power-up state
// RQ18: accepted set answers 0x62, empty payload
// RQ19: query command 0x23 with one index byte
// RQ20: query answers 0x63 with four bytes
// RQ21: report requested level 0-100
// RQ22: fourth byte returns stored config
// RQ23: query clears the reported edge flags
// RQ24: bad index or value errors, nothing changes
`timescale 1ns/10ps
`include "gpc_map.svh"
module gpc_pin_ctrl #(
   parameter int STEP_CYC = `GPC_STEP_CYC,
   parameter int SAMPLE_CYC = `GPC_SAMPLE_CYC
)
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic cmd_valid,
   input wire gpc_pkg::gpc_byte_t cmd_type,
   input wire logic [1:0] cmd_len,
   input wire gpc_pkg::gpc_byte_t cmd_idx,
   input wire gpc_pkg::gpc_byte_t cmd_val,
   input wire gpc_pkg::gpc_byte_t cmd_cfg,
   input wire logic store_boot,
   input wire logic load_boot,
   input wire logic [4:0] gpio_in,
   input wire logic host_power_ctrl,
   input wire logic host_reset_ctrl,
   input wire logic one_wire_sensor_io_out,
   output logic rsp_valid,
   output logic rsp_error,
   output gpc_pkg::gpc_byte_t rsp_type,
   output logic [2:0] rsp_len,
   output gpc_pkg::gpc_byte_t rsp_d0,
   output gpc_pkg::gpc_byte_t rsp_d1,
   output gpc_pkg::gpc_byte_t rsp_d2,
   output gpc_pkg::gpc_byte_t rsp_d3,
   output logic [12:0] pad_out,
   output logic [12:0] pad_oe,
   output logic [12:0] pad_pu,
   output logic [12:0] pad_pd,
   output logic [12:0] pad_slow,
   output logic [4:0] user_sel,
   output logic [4:0] gpio_level
);
   import gpc_pkg::*;

   localparam int NG = `GPC_NUM_GPIO;
   localparam int NP = `GPC_NUM_PINS;
   localparam int SW = $clog2(SAMPLE_CYC);
   localparam int PW = $clog2(STEP_CYC);

   gpc_byte_t val [NP];
   logic [3:0] cfg [NP];
   gpc_byte_t boot_val [NP];
   logic [3:0] boot_cfg [NP];
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic [4:0] rise;
   logic [4:0] fall;
   logic [SW-1:0] samp_cnt;
   logic samp_tick;
   logic primed;
   logic [PW-1:0] step_cnt;
   logic [6:0] phase;
   logic [NP-1:0] pwm_lvl;
   logic [NP-1:0] pin_lvl;
   logic [4:0] dflt_lvl;
   logic idx_ok;
   logic set_ok;
   logic qry_ok;
   logic [4:0] clr;

   // Config byte check: upper bits zero, drive code not reserved
   function automatic logic cfg_good(input gpc_byte_t c);
      cfg_good = (c[7:4] == 4'h0) && (c[2:0] != `GPC_DRV_RESERVED);
   endfunction

   // ******************************************************************
   // Command decode
   // ******************************************************************
   always_comb
   begin
      idx_ok = cmd_idx < `GPC_IDX_LIMIT; // RQ8
      set_ok = cmd_valid && (cmd_type == `GPC_CMD_SET) && idx_ok // RQ7
         && (cmd_val <= `GPC_VAL_HIGH) // RQ9
         && ((cmd_len == 2'h2) || ((cmd_len == 2'h3) && cfg_good(cmd_cfg))); // RQ10 RQ13
      qry_ok = cmd_valid && (cmd_type == `GPC_CMD_QRY) && idx_ok && (cmd_len == 2'h1); // RQ19
      clr = '0;
      if (qry_ok && (cmd_idx < 8'(NG)))
      begin
         clr[cmd_idx[2:0]] = 1'b1; // RQ23
      end
   end

   // ******************************************************************
   // PWM time base, 100 steps per 10 ms
   // ******************************************************************
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         step_cnt <= '0;
         phase <= 7'h00;
      end
      else if (step_cnt == PW'(STEP_CYC - 1))
      begin
         step_cnt <= '0;
         phase <= (phase == 7'h63) ? 7'h00 : phase + 7'h01; // RQ2
      end
      else
      begin
         step_cnt <= step_cnt + PW'(1);
      end
   end

   assign dflt_lvl = {one_wire_sensor_io_out, host_reset_ctrl, host_power_ctrl, 1'b1, 1'b0}; // RQ16

   always_comb
   begin
      for (int i = 0; i < NP; i++)
      begin
         pwm_lvl[i] = {1'b0, phase} < val[i]; // RQ9
         if (i < NG)
         begin
            pin_lvl[i] = cfg[i][`GPC_CFG_FUNC_BIT] ? pwm_lvl[i] : dflt_lvl[i]; // RQ14
         end
         else
         begin
            pin_lvl[i] = pwm_lvl[i]; // RQ15
         end
      end
   end

   for (genvar g = 0; g < NP; g++)
   begin : g_pin
      gpc_pin_drive u_drive
      (
         .sys_clk(sys_clk),
         .rst_b(rst_b),
         .drive_mode_field(cfg[g][2:0]),
         .level(pin_lvl[g]),
         .pad_out(pad_out[g]),
         .pad_oe(pad_oe[g]),
         .pad_pu(pad_pu[g]),
         .pad_pd(pad_pd[g]),
         .pad_slow(pad_slow[g])
      );
   end

   // ******************************************************************
   // Input sampling and edge flags
   // ******************************************************************
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sync1 <= 5'h00;
         sync2 <= 5'h00;
      end
      else
      begin
         sync1 <= gpio_in; // RQ1
         sync2 <= sync1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         samp_cnt <= '0;
         samp_tick <= 1'b0;
         primed <= 1'b0;
      end
      else
      begin
         samp_tick <= samp_cnt == SW'(SAMPLE_CYC - 1); // RQ3
         samp_cnt <= (samp_cnt == SW'(SAMPLE_CYC - 1)) ? '0 : samp_cnt + SW'(1);
         primed <= primed || samp_tick; // RQ4
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         gpio_level <= 5'h00;
      end
      else if (samp_tick)
      begin
         gpio_level <= sync2; // RQ3 RQ5
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rise <= 5'h00;
         fall <= 5'h00;
      end
      else
      begin
         for (int i = 0; i < NG; i++)
         begin
            if (samp_tick && primed && sync2[i] && !gpio_level[i])
            begin
               rise[i] <= 1'b1; // RQ4
            end
            else if (clr[i])
            begin
               rise[i] <= 1'b0; // RQ23
            end
            if (samp_tick && primed && !sync2[i] && gpio_level[i])
            begin
               fall[i] <= 1'b1; // RQ4
            end
            else if (clr[i])
            begin
               fall[i] <= 1'b0; // RQ23
            end
         end
      end
   end

   // ******************************************************************
   // Pin settings and power-up copy
   // ******************************************************************
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < NP; i++)
         begin
            val[i] <= `GPC_RST_VAL;
            cfg[i] <= (i < NG) ? `GPC_RST_GPIO_CFG : `GPC_RST_LED_CFG; // RQ16
         end
      end
      else if (set_ok)
      begin
         val[cmd_idx[3:0]] <= cmd_val; // RQ7
         if (cmd_len == 2'h3)
         begin
            cfg[cmd_idx[3:0]] <= cmd_cfg[3:0]; // RQ7
         end
      end
      else if (load_boot)
      begin
         for (int i = 0; i < NP; i++)
         begin
            val[i] <= boot_val[i]; // RQ17
            cfg[i] <= boot_cfg[i];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < NP; i++)
         begin
            boot_val[i] <= `GPC_RST_VAL;
            boot_cfg[i] <= (i < NG) ? `GPC_RST_GPIO_CFG : `GPC_RST_LED_CFG;
         end
      end
      else if (store_boot)
      begin
         for (int i = 0; i < NP; i++)
         begin
            boot_val[i] <= val[i]; // RQ17
            boot_cfg[i] <= cfg[i];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         user_sel <= 5'h00;
      end
      else
      begin
         for (int i = 0; i < NG; i++)
         begin
            user_sel[i] <= cfg[i][`GPC_CFG_FUNC_BIT]; // RQ14
         end
      end
   end

   // ******************************************************************
   // Responses
   // ******************************************************************
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rsp_valid <= 1'b0;
         rsp_error <= 1'b0;
         rsp_type <= 8'h00;
         rsp_len <= 3'h0;
         rsp_d0 <= 8'h00;
         rsp_d1 <= 8'h00;
         rsp_d2 <= 8'h00;
         rsp_d3 <= 8'h00;
      end
      else
      begin
         rsp_valid <= cmd_valid;
         rsp_error <= cmd_valid && !set_ok && !qry_ok; // RQ24
         rsp_len <= 3'h0;
         rsp_d0 <= 8'h00;
         rsp_d1 <= 8'h00;
         rsp_d2 <= 8'h00;
         rsp_d3 <= 8'h00;
         if (set_ok)
         begin
            rsp_type <= `GPC_RSP_SET; // RQ18
         end
         else if (qry_ok)
         begin
            rsp_type <= `GPC_RSP_QRY; // RQ20
            rsp_len <= `GPC_RSP_QRY_LEN;
            rsp_d0 <= cmd_idx;
            if (cmd_idx < 8'(NG))
            begin
               rsp_d1 <= {5'h00, fall[cmd_idx[2:0]], rise[cmd_idx[2:0]],
                  gpio_level[cmd_idx[2:0]]}; // RQ4
            end
            else
            begin
               rsp_d1 <= {7'h00, pad_out[cmd_idx[3:0]]};
            end
            rsp_d2 <= val[cmd_idx[3:0]]; // RQ21
            rsp_d3 <= {4'h0, cfg[cmd_idx[3:0]]}; // RQ22
         end
         else
         begin
            rsp_type <= `GPC_RSP_ERR_BASE | {2'h0, cmd_type[5:0]}; // RQ13 RQ24
         end
      end
   end

   // ******************************************************************
   // Checks
   // ******************************************************************
   a_set_ack_type: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ18
      set_ok |=> rsp_valid && !rsp_error && rsp_type == 8'h62 && rsp_len == 3'h0)
      else $error("set not answered with empty 0x62");
   a_qry_answer: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ20
      qry_ok |=> rsp_type == 8'h63 && rsp_len == 3'h4 && rsp_d0 == $past(cmd_idx))
      else $error("query answer malformed");
   a_bad_idx_err: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ8
      cmd_valid && cmd_idx >= 8'h0D |=> rsp_valid && rsp_error)
      else $error("inaccessible index not refused");
   a_rsvd_drive_err: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ13
      cmd_valid && cmd_type == 8'h22 && cmd_len == 2'h3 && cmd_cfg[2:0] == 3'h6
      |=> rsp_error)
      else $error("reserved drive code accepted");
   a_bad_val_keep: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ24
      cmd_valid && cmd_type == 8'h22 && cmd_idx == 8'h00 && cmd_val > 8'h64 && !load_boot
      |=> rsp_error && val[0] == $past(val[0]) && cfg[0] == $past(cfg[0]))
      else $error("invalid value changed pin");
   a_edge_clear: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ23
      qry_ok && cmd_idx == 8'h00 && !samp_tick |=> !rise[0] && !fall[0])
      else $error("edge flags survive query");
   a_rise_latch: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ4
      samp_tick && primed && sync2[0] && !gpio_level[0] |=> rise[0] && gpio_level[0])
      else $error("rising edge not latched");
   a_level_on_tick: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ5
      $changed(gpio_level) |-> $past(samp_tick))
      else $error("level changed between samples");
   a_pwm_phase: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ9
      phase <= 7'h63 && (phase != 7'h00 || pwm_lvl[5] == (val[5] != 8'h00)))
      else $error("pwm phase out of range");

endmodule

// ==== dv/gpc_pin_world.sv ====
// Purpose: pin-side world of the five general pins: switches, pulls, host sense
// Assumes: pad controls come straight from the pin controller
// Notes: undriven, unpulled pins 0, 2 and 3 toggle every cycle; pin 1 follows host_on, pin 4 reads one
`timescale 1ns/10ps
module gpc_pin_world
(
   input wire logic sys_clk,
   input wire logic [4:0] pad_out,
   input wire logic [4:0] pad_oe,
   input wire logic [4:0] pad_pu,
   input wire logic [4:0] pad_pd,
   input wire logic [4:0] sw_closed,
   input wire logic host_on,
   output logic [4:0] gpio_in
);
   logic flt = 1'b0;

   // ************************************************************
   // Pin level resolution
   // ************************************************************
   always @(posedge sys_clk)
   begin
      flt <= ~flt;
   end

   always_comb
   begin
      for (int i = 0; i < 5; i++)
      begin
         if (pad_oe[i] === 1'b1)
            gpio_in[i] = pad_out[i];
         else if (sw_closed[i])
            gpio_in[i] = 1'b0;
         else if (pad_pu[i] === 1'b1)
            gpio_in[i] = 1'b1;
         else if (pad_pd[i] === 1'b1)
            gpio_in[i] = 1'b0;
         else if (i == 4)
            gpio_in[i] = 1'b1;
         else if (i == 1)
            gpio_in[i] = host_on;
         else
            gpio_in[i] = flt;
      end
   end
endmodule

// ==== dv/tb_top.sv ====
// Purpose: self-checking bench of the pin controller
// Assumes: shortened PWM step and sample period
// Notes: responses checked from a queue of expectations
`timescale 1ns/10ps
`include "gpc_map.svh"
module tb_top;
   import gpc_pkg::*;
   typedef struct {logic e; gpc_byte_t t; logic [2:0] l; gpc_byte_t a, b, m, c, d;} gpc_exp_s;
   localparam int STEP = 2;
   localparam int SAMP = 12;
   localparam int WAIT_S = 3 * SAMP + 4;
   logic sys_clk, rst_b, cmd_valid, store_boot, load_boot, host_on;
   logic host_power_ctrl, host_reset_ctrl, one_wire_sensor_io_out, rsp_valid, rsp_error;
   gpc_byte_t cmd_type, cmd_idx, cmd_val, cmd_cfg, rsp_type, rsp_d0, rsp_d1, rsp_d2, rsp_d3;
   logic [1:0] cmd_len;
   logic [2:0] rsp_len;
   logic [12:0] pad_out, pad_oe, pad_pu, pad_pd, pad_slow;
   logic [4:0] user_sel, gpio_level, gpio_in, sw_closed;
   int failures = 0;
   int samples_checked = 0;
   int cyc = 0;
   int duty[5] = '{0, 1, 30, 99, 100};
   gpc_exp_s exp_q[$];
   gpc_exp_s x;
   gpc_byte_t val_m[13], cfg_m[13];

   // ************************************************************
   // Design, pin world and clock
   // ************************************************************
   gpc_pin_ctrl #(.STEP_CYC(STEP), .SAMPLE_CYC(SAMP)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
      .cmd_valid(cmd_valid), .cmd_type(cmd_type), .cmd_len(cmd_len), .cmd_idx(cmd_idx),
      .cmd_val(cmd_val), .cmd_cfg(cmd_cfg), .store_boot(store_boot), .load_boot(load_boot),
      .gpio_in(gpio_in), .host_power_ctrl(host_power_ctrl), .host_reset_ctrl(host_reset_ctrl),
      .one_wire_sensor_io_out(one_wire_sensor_io_out), .rsp_valid(rsp_valid),
      .rsp_error(rsp_error), .rsp_type(rsp_type), .rsp_len(rsp_len), .rsp_d0(rsp_d0),
      .rsp_d1(rsp_d1), .rsp_d2(rsp_d2), .rsp_d3(rsp_d3), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pu(pad_pu), .pad_pd(pad_pd), .pad_slow(pad_slow), .user_sel(user_sel),
      .gpio_level(gpio_level));
   gpc_pin_world world_u (.sys_clk(sys_clk), .pad_out(pad_out[4:0]), .pad_oe(pad_oe[4:0]),
      .pad_pu(pad_pu[4:0]), .pad_pd(pad_pd[4:0]), .sw_closed(sw_closed), .host_on(host_on),
      .gpio_in(gpio_in));

   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         failures++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, want);
      end
   endtask

   task automatic end_sim;
      if (failures == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic cmd(input gpc_byte_t t, input logic [1:0] l, input gpc_byte_t i, v, c);
      cmd_valid = 1'b1;
      cmd_type = t;
      cmd_len = l;
      cmd_idx = i;
      cmd_val = v;
      cmd_cfg = c;
      @(negedge sys_clk);
   endtask

   task automatic idle(input int n);
      cmd_valid = 1'b0;
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic ok_set(input gpc_byte_t i, v, c, input logic [1:0] l);
      exp_q.push_back('{1'b0, `GPC_RSP_SET, 3'h0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
      cmd(`GPC_CMD_SET, l, i, v, c);
      val_m[i] = v;
      if (l == 2'h3)
         cfg_m[i] = c;
   endtask

   task automatic bad(input gpc_byte_t t, input logic [1:0] l, input gpc_byte_t i, v, c);
      exp_q.push_back('{1'b1, `GPC_RSP_ERR_BASE | {2'h0, t[5:0]}, 3'h0, 8'h00, 8'h00, 8'h00,
         8'h00, 8'h00});
      cmd(t, l, i, v, c);
   endtask

   task automatic qry(input gpc_byte_t i, d1, m);
      exp_q.push_back('{1'b0, `GPC_RSP_QRY, `GPC_RSP_QRY_LEN, i, d1, m, val_m[i], cfg_m[i]});
      cmd(`GPC_CMD_QRY, 2'h1, i, 8'h00, 8'h00);
   endtask

   function automatic logic [3:0] exp_drv(input logic [2:0] c, input logic l);
      case (c)
         3'h0: return {l, 1'b0, !l, 1'b0};
         3'h1: return 4'h8;
         3'h3: return {!l, l, 2'h0};
         3'h4: return {l, 3'h1};
         3'h5: return 4'h9;
         3'h7: return {!l, 3'h1};
         default: return 4'h0;
      endcase
   endfunction

   // ************************************************************
   // Response monitor and timeout
   // ************************************************************
   always @(negedge sys_clk)
   begin
      if (rsp_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk(16'h1, 16'h0);
         else
         begin
            x = exp_q.pop_front();
            chk(rsp_error, x.e);
            chk(rsp_type, x.t);
            chk(rsp_len, x.l);
            chk(rsp_d0, x.a);
            chk(rsp_d1 & x.m, x.b & x.m);
            chk(rsp_d2, x.c);
            chk(rsp_d3, x.d);
         end
      end
   end

   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         end_sim();
      end
   end

   // ************************************************************
   // Scenarios
   // ************************************************************
   initial
   begin
      gpc_byte_t k;
      int cnt;
      {rst_b, cmd_valid, store_boot, load_boot, cmd_len, sw_closed} = '0;
      {cmd_type, cmd_idx, cmd_val, cmd_cfg} = '0;
      {host_power_ctrl, host_reset_ctrl, one_wire_sensor_io_out} = '0;
      host_on = 1'b1;
      void'($urandom(32'h8198));
      for (int i = 0; i < 13; i++)
      begin
         val_m[i] = `GPC_RST_VAL;
         cfg_m[i] = (i < 5) ? 8'h02 : 8'h01;
      end
      repeat (8) @(negedge sys_clk);
      rst_b = 1'b1;
      idle(WAIT_S);
      chk(pad_oe, 16'h1FE0);
      chk(pad_out, 16'h0002);
      chk(gpio_level[1], host_on);
      chk(user_sel, 16'h0);
      for (int i = 0; i < 13; i++)
         qry(8'(i), (i == 1 || i == 4) ? 8'h01 : 8'h00,
            (i < 5 && i != 1 && i != 4) ? 8'h00 : 8'h07);
      bad(`GPC_CMD_SET, 2'h3, 8'h0D, 8'h00, 8'h01);
      bad(`GPC_CMD_SET, 2'h3, 8'hFF, 8'h00, 8'h01);
      bad(`GPC_CMD_SET, 2'h2, 8'h00, 8'h65, 8'h01);
      bad(`GPC_CMD_SET, 2'h2, 8'h05, 8'hFE, 8'h01);
      bad(`GPC_CMD_SET, 2'h3, 8'h05, 8'h32, 8'h0E);
      bad(`GPC_CMD_SET, 2'h3, 8'h05, 8'h32, 8'h15);
      bad(`GPC_CMD_SET, 2'h1, 8'h05, 8'h32, 8'h01);
      bad(`GPC_CMD_QRY, 2'h1, 8'h0D, 8'h00, 8'h00);
      bad(`GPC_CMD_QRY, 2'h2, 8'h05, 8'h00, 8'h00);
      bad(8'h05, 2'h1, 8'h05, 8'h00, 8'h00);
      qry(8'h05, 8'h00, 8'h07);
      for (int c = 0; c < 8; c++)
         for (int l = 0; l < 2 && c != 6; l++)
         begin
            k = 8'($urandom_range(12, 5));
            ok_set(k, l ? 8'h64 : 8'h00, 8'(8 + c), 2'h3);
            idle(2);
            chk({pad_oe[k], pad_pu[k], pad_pd[k], pad_slow[k]}, exp_drv(3'(c), l[0]));
            chk(pad_out[k], l[0]);
         end
      ok_set(8'h07, 8'h32, 8'h05, 2'h3);
      ok_set(8'h07, 8'h14, 8'hFF, 2'h2);
      qry(8'h07, 8'h00, 8'h00);
      for (int j = 0; j < 5; j++)
      begin
         ok_set(8'h09, 8'(duty[j]), 8'h01, 2'h3);
         idle(4);
         cnt = 0;
         repeat (100 * STEP) @(negedge sys_clk) if (pad_out[9] === 1'b1) cnt++;
         chk(cnt[15:0], 16'(duty[j] * STEP));
      end
      ok_set(8'h00, 8'h00, 8'h09, 2'h3);
      idle(WAIT_S);
      qry(8'h00, 8'h00, 8'h00);
      ok_set(8'h00, 8'h64, 8'hFF, 2'h2);
      idle(WAIT_S);
      qry(8'h00, 8'h03, 8'h07);
      qry(8'h00, 8'h01, 8'h07);
      ok_set(8'h00, 8'h00, 8'hFF, 2'h2);
      idle(WAIT_S);
      qry(8'h00, 8'h04, 8'h07);
      ok_set(8'h00, 8'h64, 8'h0B, 2'h3);
      idle(WAIT_S);
      qry(8'h00, 8'h01, 8'h01);
      sw_closed[0] = 1'b1;
      idle(WAIT_S);
      qry(8'h00, 8'h00, 8'h01);
      sw_closed[0] = 1'b0;
      for (int p = 2; p < 5; p++)
      begin
         ok_set(8'(p), 8'h00, 8'h01, 2'h3);
         repeat (3)
         begin
            {host_power_ctrl, host_reset_ctrl, one_wire_sensor_io_out} = 3'($urandom);
            idle(3);
            chk(pad_out[p], (p == 2) ? host_power_ctrl : (p == 3) ? host_reset_ctrl
               : one_wire_sensor_io_out);
            chk(user_sel[p], 1'b0);
         end
         ok_set(8'(p), 8'h64, 8'h09, 2'h3);
         idle(3);
         chk({pad_out[p], user_sel[p]}, 2'h3);
      end
      ok_set(8'h08, 8'h64, 8'h05, 2'h3);
      idle(1);
      store_boot = 1'b1;
      idle(1);
      store_boot = 1'b0;
      ok_set(8'h08, 8'h00, 8'h01, 2'h3);
      idle(1);
      load_boot = 1'b1;
      idle(1);
      load_boot = 1'b0;
      val_m[8] = 8'h64;
      cfg_m[8] = 8'h05;
      idle(2);
      qry(8'h08, 8'h01, 8'h07);
      idle(3);
      chk(16'(exp_q.size()), 16'h0);
      end_sim();
   end
endmodule
